// ### icmo_pkg.sv
// Shared constants and types for the instruction-cache maintenance block
package icmo_pkg;
    localparam int ADDR_W = 32;
    localparam int WORD_W = 32;
    localparam int REGSEL_W = 5;
    localparam int CLASS_W = 8;
    localparam int WORDSEL_W = 3;
    localparam int TAG_W = 22;
    // EA bits 19:26 (bit 0 = msb) sit at [12:5]; 27:29 at [4:2]; tag 0:21 at [31:10]
    localparam int EA_CLASS_LSB = 5;
    localparam int EA_WORD_LSB = 2;
    localparam int EA_TAG_LSB = 10;
    // Debug data register: line_field_a 0:21 -> [31:10], valid 27 -> [4], LRU 31 -> [0]
    localparam int DBG_LINE_FIELD_A_LSB = 10;
    localparam int DBG_VALID_POS = 4;
    localparam int DBG_LRU_POS = 0;
    localparam logic [31:0] DBG_DATA_RESET = 32'h0000_0000;
    localparam logic [4:0] BASE_FIELD_ZERO = 5'h00;
    localparam logic WAY_A = 1'b0;
    localparam logic WAY_B = 1'b1;

    typedef enum logic [1:0] {
        ICMO_OP_TOUCH = 2'h0,
        ICMO_OP_INVAL_ALL = 2'h1,
        ICMO_OP_DBG_READ = 2'h2,
        ICMO_OP_NONE = 2'h3
    } icmo_op_kind_t;

    typedef enum logic [4:0] {
        ICMO_ST_IDLE = 5'b0_0001,
        ICMO_ST_EXEC = 5'b0_0010,
        ICMO_ST_FILL = 5'b0_0100,
        ICMO_ST_DBG = 5'b0_1000,
        ICMO_ST_DONE = 5'b1_0000
    } icmo_state_t;

    typedef struct packed {
        icmo_op_kind_t kind;
        logic [REGSEL_W-1:0] base_reg_field;
        logic [ADDR_W-1:0] base_val;
        logic [ADDR_W-1:0] index_val;
        logic user_mode;
        logic cachable;
        logic xlate_fault;
        logic dac_hit;
        logic reserved_nz;
    } icmo_op_t;

    typedef struct packed {
        logic done;
        logic exc_program;
        logic exc_data;
        logic exc_debug;
    } icmo_result_t;
endpackage

// ### icmo_ea_gen.sv
// Effective address adder for touch and debug-read operations
`timescale 1ns/1ps
`default_nettype none
module icmo_ea_gen #(
    parameter int ADDR_W = 32
) (
    input wire logic [4:0] base_reg_field_i,
    input wire logic [ADDR_W-1:0] base_val_i,
    input wire logic [ADDR_W-1:0] index_val_i,
    output logic [ADDR_W-1:0] ea_o
);
    logic [ADDR_W-1:0] base;

    always_comb begin
        // Field value zero means literal zero, not register zero
        base = (base_reg_field_i == icmo_pkg::BASE_FIELD_ZERO) ? '0 : base_val_i;
        ea_o = base + index_val_i;
    end
endmodule // icmo_ea_gen
`default_nettype wire

// ### icmo_core.sv
// Instruction-cache maintenance: touch, invalidate-all, debug read
// What this block does
// - Touch and debug-read address is index plus base, base zero when field zero.
// - Cachable touch that misses fetches the line and installs it.
// - Touch is a no-op on hit or non-cachable address.
// - Touch with translation or storage fault raises no data or program exception, completes as no-op.
// - Touch is checked like a load by the data address-compare debug logic.
// - Exceptions of these operations report as data-side, never instruction-side.
// - Nonzero reserved bits need not raise illegal-instruction; outcome bounded.
// - Invalidate-all clears valid of every line in every class and way.
// - Invalidate-all in user mode is suppressed and raises a program exception.
// - Invalidate-all never raises data storage, translation or compare exceptions.
// - Debug read in user mode is a privilege violation.
// - Debug read selects the congruence class from address bits 19 to 26.
// - Way-select bit 0 picks way A, 1 picks way B.
// - Line_field_a-select 0 returns word chosen by bits 27 to 29; 1 returns tag.
// - Word or tag lands in debug bits 0 to 21; 22 to 26 reserved.
// - Valid bit copied to debug bit 27; bits 28 to 30 reserved.
// - Class replacement bit copied to debug bit 31; 0 means way A LRU.
// - Debug-data reads are not interlocked against a pending debug-read update.
// - Context sync waits for all prior operations and discards prefetched fetches.
`timescale 1ns/1ps
`default_nettype none
module icmo_core #(
    parameter int CLASS_W = icmo_pkg::CLASS_W,
    parameter int WORDSEL_W = icmo_pkg::WORDSEL_W
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Operation port from the execution pipeline
    input wire logic op_valid_i,
    input wire icmo_pkg::icmo_op_t op_i,
    output logic op_ready_o,
    output icmo_pkg::icmo_result_t result_o,
    // Core configuration bits
    input wire logic way_select_bit_i,
    input wire logic line_field_a_select_bit_i,
    // Line fill from main memory
    output logic fill_req_o,
    output logic [icmo_pkg::ADDR_W-1:0] fill_addr_o,
    input wire logic fill_valid_i,
    input wire logic [icmo_pkg::WORD_W-1:0] fill_data_i,
    // Instruction fetch lookup
    input wire logic fetch_valid_i,
    input wire logic [icmo_pkg::ADDR_W-1:0] fetch_addr_i,
    output logic fetch_hit_o,
    output logic [icmo_pkg::WORD_W-1:0] fetch_word_o,
    // Context synchronisation
    input wire logic ctx_sync_i,
    output logic ctx_sync_done_o,
    output logic prefetch_flush_o,
    // Debug data register, read as a special register
    output logic [icmo_pkg::WORD_W-1:0] instr_cache_debug_data_o
);
    localparam int NUM_CLASSES = 1 << CLASS_W;
    localparam int WORDS = 1 << WORDSEL_W;
    localparam int TAG_W = icmo_pkg::TAG_W;

    icmo_pkg::icmo_state_t state;
    icmo_pkg::icmo_op_t op_q;
    logic [icmo_pkg::ADDR_W-1:0] ea;
    logic [icmo_pkg::ADDR_W-1:0] ea_q;
    logic [CLASS_W-1:0] cls_q;
    logic [WORDSEL_W-1:0] wsel_q;
    logic [TAG_W-1:0] tag_q;

    // Storage: data and tags as arrays, valid and LRU as flops so a full clear is one cycle
    logic [icmo_pkg::WORD_W-1:0] data_mem [NUM_CLASSES*2*WORDS];
    logic [TAG_W-1:0] tag_mem [NUM_CLASSES*2];
    logic [2*NUM_CLASSES-1:0] valid_q;
    logic [NUM_CLASSES-1:0] lru_q;

    logic hit_a;
    logic hit_b;
    logic fill_way;
    logic [WORDSEL_W-1:0] fill_cnt;
    logic fill_last;
    logic sync_pending;
    logic [CLASS_W-1:0] fetch_cls;
    logic [TAG_W-1:0] fetch_tag;
    logic fetch_hit;
    logic fetch_way;

    icmo_ea_gen #(
        .ADDR_W(icmo_pkg::ADDR_W)
    ) u_ea (
        .base_reg_field_i(op_i.base_reg_field),
        .base_val_i(op_i.base_val),
        .index_val_i(op_i.index_val),
        .ea_o(ea)
    );

    assign op_ready_o = (state == icmo_pkg::ICMO_ST_IDLE);

    // Lookup of the latched operation address in both ways
    always_comb begin
        hit_a = valid_q[{cls_q, icmo_pkg::WAY_A}] &&
                (tag_mem[{cls_q, icmo_pkg::WAY_A}] == tag_q);
        hit_b = valid_q[{cls_q, icmo_pkg::WAY_B}] &&
                (tag_mem[{cls_q, icmo_pkg::WAY_B}] == tag_q);
    end

    assign fill_last = fill_valid_i && (fill_cnt == WORDSEL_W'(WORDS - 1));
    assign fill_req_o = (state == icmo_pkg::ICMO_ST_FILL);
    assign fill_addr_o = {ea_q[icmo_pkg::ADDR_W-1:icmo_pkg::EA_CLASS_LSB],
                          {icmo_pkg::EA_CLASS_LSB{1'b0}}};

    // Latch the request; reserved-bit contents are simply not decoded
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            op_q <= '0;
            ea_q <= '0;
            cls_q <= '0;
            wsel_q <= '0;
            tag_q <= '0;
        end else if (op_valid_i && op_ready_o) begin
            op_q <= op_i;
            ea_q <= ea;
            cls_q <= ea[icmo_pkg::EA_CLASS_LSB +: CLASS_W];
            wsel_q <= ea[icmo_pkg::EA_WORD_LSB +: WORDSEL_W];
            tag_q <= ea[icmo_pkg::EA_TAG_LSB +: TAG_W];
        end
    end

    // Operation sequencer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state <= icmo_pkg::ICMO_ST_IDLE;
        end else begin
            unique case (state)
                icmo_pkg::ICMO_ST_IDLE: begin
                    if (op_valid_i && op_i.kind != icmo_pkg::ICMO_OP_NONE) begin
                        state <= icmo_pkg::ICMO_ST_EXEC;
                    end
                end
                icmo_pkg::ICMO_ST_EXEC: begin
                    if (op_q.kind == icmo_pkg::ICMO_OP_TOUCH && op_q.cachable &&
                        !op_q.xlate_fault && !hit_a && !hit_b) begin
                        state <= icmo_pkg::ICMO_ST_FILL;
                    end else if (op_q.kind == icmo_pkg::ICMO_OP_DBG_READ &&
                                 !op_q.user_mode && !op_q.xlate_fault) begin
                        state <= icmo_pkg::ICMO_ST_DBG;
                    end else begin
                        state <= icmo_pkg::ICMO_ST_DONE;
                    end
                end
                icmo_pkg::ICMO_ST_FILL: begin
                    if (fill_last) begin
                        state <= icmo_pkg::ICMO_ST_DONE;
                    end
                end
                icmo_pkg::ICMO_ST_DBG: begin
                    state <= icmo_pkg::ICMO_ST_DONE;
                end
                icmo_pkg::ICMO_ST_DONE: begin
                    state <= icmo_pkg::ICMO_ST_IDLE;
                end
                default: begin
                    state <= icmo_pkg::ICMO_ST_IDLE;
                end
            endcase
        end
    end

    // Completion and exception pulses, only on data-side outputs
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            result_o <= '0;
        end else begin
            result_o <= '0;
            if (state == icmo_pkg::ICMO_ST_EXEC) begin
                unique case (op_q.kind)
                    icmo_pkg::ICMO_OP_TOUCH: begin
                        // Faults swallowed; address compare still applies as for a load
                        result_o.exc_debug <= op_q.dac_hit;
                    end
                    icmo_pkg::ICMO_OP_INVAL_ALL: begin
                        result_o.exc_program <= op_q.user_mode;
                    end
                    icmo_pkg::ICMO_OP_DBG_READ: begin
                        result_o.exc_program <= op_q.user_mode;
                        result_o.exc_data <= !op_q.user_mode && op_q.xlate_fault;
                    end
                    default: begin
                        result_o <= '0;
                    end
                endcase
            end
            if (state == icmo_pkg::ICMO_ST_DONE) begin
                result_o.done <= 1'b1;
            end
        end
    end

    // Fill word counter and victim way choice
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fill_cnt <= '0;
            fill_way <= icmo_pkg::WAY_A;
        end else if (state == icmo_pkg::ICMO_ST_EXEC) begin
            fill_cnt <= '0;
            fill_way <= lru_q[cls_q];
        end else if (state == icmo_pkg::ICMO_ST_FILL && fill_valid_i) begin
            fill_cnt <= fill_cnt + WORDSEL_W'(1);
        end
    end

    // Data and tag arrays; written only by fills
    always_ff @(posedge clk_i) begin
        if (state == icmo_pkg::ICMO_ST_FILL && fill_valid_i) begin
            data_mem[{cls_q, fill_way, fill_cnt}] <= fill_data_i;
            if (fill_last) begin
                tag_mem[{cls_q, fill_way}] <= tag_q;
            end
        end
    end

    // Valid bits: whole-cache clear wins over nothing else, as no fill runs alongside
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            valid_q <= '0;
        end else if (state == icmo_pkg::ICMO_ST_EXEC &&
                     op_q.kind == icmo_pkg::ICMO_OP_INVAL_ALL && !op_q.user_mode) begin
            valid_q <= '0;
        end else if (state == icmo_pkg::ICMO_ST_FILL && fill_last) begin
            valid_q[{cls_q, fill_way}] <= 1'b1;
        end
    end

    // Replacement bits: filled way becomes most recent; fetched way too, except in a fill's last-word cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lru_q <= '0;
        end else if (state == icmo_pkg::ICMO_ST_FILL && fill_last) begin
            lru_q[cls_q] <= ~fill_way;
        end else if (fetch_valid_i && fetch_hit) begin
            lru_q[fetch_cls] <= ~fetch_way;
        end
    end

    // Fetch lookup, answered one cycle later
    always_comb begin
        fetch_cls = fetch_addr_i[icmo_pkg::EA_CLASS_LSB +: CLASS_W];
        fetch_tag = fetch_addr_i[icmo_pkg::EA_TAG_LSB +: TAG_W];
        fetch_way = valid_q[{fetch_cls, icmo_pkg::WAY_B}] &&
                    (tag_mem[{fetch_cls, icmo_pkg::WAY_B}] == fetch_tag);
        fetch_hit = fetch_way || (valid_q[{fetch_cls, icmo_pkg::WAY_A}] &&
                    (tag_mem[{fetch_cls, icmo_pkg::WAY_A}] == fetch_tag));
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            fetch_hit_o <= 1'b0;
            fetch_word_o <= '0;
        end else begin
            fetch_hit_o <= fetch_valid_i && fetch_hit;
            fetch_word_o <= data_mem[{fetch_cls, fetch_way,
                                      fetch_addr_i[icmo_pkg::EA_WORD_LSB +: WORDSEL_W]}];
        end
    end

    // Debug data register; software must sync before reading, no interlock here
    logic [TAG_W-1:0] dbg_line_field_a;
    logic [WORDSEL_W-1:0] dbg_unused;
    logic [icmo_pkg::WORD_W-1:0] dbg_word;
    always_comb begin
        dbg_unused = '0;
        dbg_word = data_mem[{cls_q, way_select_bit_i, wsel_q}];
        if (line_field_a_select_bit_i) begin
            dbg_line_field_a = tag_mem[{cls_q, way_select_bit_i}];
        end else begin
            dbg_line_field_a = dbg_word[icmo_pkg::DBG_LINE_FIELD_A_LSB +: TAG_W];
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            instr_cache_debug_data_o <= icmo_pkg::DBG_DATA_RESET;
        end else if (state == icmo_pkg::ICMO_ST_DBG) begin
            instr_cache_debug_data_o <= icmo_pkg::DBG_DATA_RESET;
            instr_cache_debug_data_o[icmo_pkg::DBG_LINE_FIELD_A_LSB +: TAG_W] <= dbg_line_field_a;
            instr_cache_debug_data_o[icmo_pkg::DBG_VALID_POS] <=
                valid_q[{cls_q, way_select_bit_i}];
            instr_cache_debug_data_o[icmo_pkg::DBG_LRU_POS] <= lru_q[cls_q];
        end
    end

    // Context sync: hold until the sequencer drains, then flush prefetched fetches
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sync_pending <= 1'b0;
            ctx_sync_done_o <= 1'b0;
            prefetch_flush_o <= 1'b0;
        end else begin
            ctx_sync_done_o <= 1'b0;
            prefetch_flush_o <= 1'b0;
            if ((ctx_sync_i || sync_pending) && state == icmo_pkg::ICMO_ST_IDLE &&
                !op_valid_i) begin
                sync_pending <= 1'b0;
                ctx_sync_done_o <= 1'b1;
                prefetch_flush_o <= 1'b1;
            end else if (ctx_sync_i) begin
                sync_pending <= 1'b1;
            end
        end
    end
endmodule // icmo_core
`default_nettype wire

// ### icmo_core_assertions.sv
// Port checker for the instruction-cache maintenance block
`timescale 1ns/1ps
`default_nettype none
module icmo_core_assertions (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic op_valid_i,
    input wire icmo_pkg::icmo_op_t op_i,
    input wire logic op_ready_o,
    input wire icmo_pkg::icmo_result_t result_o,
    input wire logic fill_req_o,
    input wire logic [icmo_pkg::ADDR_W-1:0] fill_addr_o,
    input wire logic ctx_sync_i,
    input wire logic ctx_sync_done_o,
    input wire logic prefetch_flush_o,
    input wire logic [icmo_pkg::WORD_W-1:0] instr_cache_debug_data_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    logic tk;
    logic tch;
    logic inv;
    logic dbg;
    assign tk = op_valid_i && op_ready_o;
    assign tch = tk && op_i.kind == icmo_pkg::ICMO_OP_TOUCH;
    assign inv = tk && op_i.kind == icmo_pkg::ICMO_OP_INVAL_ALL;
    assign dbg = tk && op_i.kind == icmo_pkg::ICMO_OP_DBG_READ;
    a_fill_line_aligned: assert property (fill_req_o |-> fill_addr_o[4:0] == 5'h00)
        else $error("fill address not line aligned");
    a_touch_skip_fill: assert property ((tch && (!op_i.cachable || op_i.xlate_fault)) |->
        ##1 !fill_req_o [*3]) else $error("touch fetched a line it must skip");
    a_touch_no_trap: assert property (tch |-> ##2 !result_o.exc_data && !result_o.exc_program)
        else $error("touch raised a data or program exception");
    a_touch_dac_debug: assert property ((tch && op_i.dac_hit) |-> ##2 result_o.exc_debug)
        else $error("touch compare match gave no debug exception");
    a_inval_quiet: assert property (inv |-> ##2 !result_o.exc_data && !result_o.exc_debug
        ##1 result_o.done) else $error("invalidate-all raised data exception");
    a_inval_user_trap: assert property ((inv && op_i.user_mode) |-> ##2 result_o.exc_program)
        else $error("user invalidate-all not trapped");
    a_dbg_user_trap: assert property ((dbg && op_i.user_mode) |=>
        ($stable(instr_cache_debug_data_o) [*4] and ##1 result_o.exc_program))
        else $error("user debug read not refused");
    a_dbg_reserved_zero: assert property (instr_cache_debug_data_o[9:5] == 5'h00 &&
        instr_cache_debug_data_o[3:1] == 3'h0) else $error("reserved debug bits set");
    a_sync_flush_pair: assert property ((ctx_sync_i && op_ready_o && !op_valid_i) |->
        ##[1:2] (ctx_sync_done_o && prefetch_flush_o)) else $error("sync not done");
    c_fill: cover property (fill_req_o);
    c_inval_user: cover property (inv && op_i.user_mode);
    c_dbg_read: cover property (dbg && !op_i.user_mode);
endmodule // icmo_core_assertions

bind icmo_core icmo_core_assertions u_chk (.clk_i, .sys_rst_i, .op_valid_i, .op_i, .op_ready_o,
    .result_o, .fill_req_o, .fill_addr_o, .ctx_sync_i, .ctx_sync_done_o, .prefetch_flush_o,
    .instr_cache_debug_data_o);
`default_nettype wire

// ### icmo_mem_model.sv
// Main memory model answering line fills, word 0 first
`timescale 1ns/1ps
`default_nettype none
module icmo_mem_model (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic slow_i,
    input wire logic fill_req_i,
    input wire logic [31:0] fill_addr_i,
    output logic fill_valid_o,
    output logic [31:0] fill_data_o
);
    logic [3:0] cnt;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt <= 4'h0;
            fill_valid_o <= 1'b0;
            fill_data_o <= 32'h0000_0000;
        end else if (fill_req_i && cnt != 4'h8 && !(slow_i && fill_valid_o)) begin
            fill_valid_o <= 1'b1;
            fill_data_o <= {cnt[2:0], fill_addr_i[23:5], 10'h2A5};
            cnt <= cnt + 4'h1;
        end else begin
            // Idle data toggles so a stale word never looks valid
            fill_valid_o <= 1'b0;
            fill_data_o <= ~fill_data_o;
            if (!fill_req_i) begin
                cnt <= 4'h0;
            end
        end
    end
endmodule // icmo_mem_model
`default_nettype wire

// ### testbench.sv
// Self-checking bench for the instruction-cache maintenance block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic op_valid_i = 1'b0;
    icmo_pkg::icmo_op_t op_i = '0;
    logic way_select_bit_i = 1'b0;
    logic line_field_a_select_bit_i = 1'b0;
    logic fetch_valid_i = 1'b0;
    logic [31:0] fetch_addr_i = 32'h0000_0000;
    logic ctx_sync_i = 1'b0;
    logic slow = 1'b0;
    logic op_ready_o, fill_req_o, fill_valid_i, fetch_hit_o, ctx_sync_done_o, prefetch_flush_o;
    logic [31:0] fill_addr_o, fill_data_i, fetch_word_o, instr_cache_debug_data_o, fa, wd;
    icmo_pkg::icmo_result_t result_o, seen;
    logic fill_seen;
    int err_total = 0;
    int n_compared = 0;
    int cycles = 0;
    localparam logic [31:0] EA = 32'h0001_2344;
    localparam logic [4:0] SUP = 5'b00100;

    icmo_core u_dut (.clk_i, .sys_rst_i, .op_valid_i, .op_i, .op_ready_o, .result_o,
        .way_select_bit_i, .line_field_a_select_bit_i, .fill_req_o, .fill_addr_o, .fill_valid_i,
        .fill_data_i, .fetch_valid_i, .fetch_addr_i, .fetch_hit_o, .fetch_word_o, .ctx_sync_i,
        .ctx_sync_done_o, .prefetch_flush_o, .instr_cache_debug_data_o);
    icmo_mem_model u_mem (.clk_i, .sys_rst_i, .slow_i(slow), .fill_req_i(fill_req_o),
        .fill_addr_i(fill_addr_o), .fill_valid_o(fill_valid_i), .fill_data_o(fill_data_i));

    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_total++;
            give_verdict();
        end
    end

    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Flags are {reserved, user, cachable, fault, compare match}
    task automatic run_op(icmo_pkg::icmo_op_kind_t k, logic [4:0] f, logic [31:0] b,
                          logic [31:0] x, logic [4:0] fl);
        seen = '0;
        fill_seen = 1'b0;
        @(posedge clk_i);
        op_valid_i <= 1'b1;
        op_i <= '{k, f, b, x, fl[3], fl[2], fl[1], fl[0], fl[4]};
        @(posedge clk_i);
        op_valid_i <= 1'b0;
        op_i.kind <= icmo_pkg::ICMO_OP_NONE;
        for (int i = 0; i < 60 && seen.done !== 1'b1; i++) begin
            @(posedge clk_i);
            #1;
            seen = seen | result_o;
            if (fill_req_o === 1'b1) begin
                fill_seen = 1'b1;
                fa = fill_addr_o;
            end
        end
        check("done", 1, seen.done);
    endtask

    task automatic dbg_read(logic w, logic s, logic [31:0] msk, logic [31:0] exp);
        way_select_bit_i <= w;
        line_field_a_select_bit_i <= s;
        run_op(icmo_pkg::ICMO_OP_DBG_READ, 5'd7, 32'h0001_0000, EA - 32'h0001_0000, SUP);
        check("debug data", exp & msk, instr_cache_debug_data_o & msk);
    endtask

    task automatic t_touches();
        run_op(icmo_pkg::ICMO_OP_TOUCH, 5'd3, 32'h0001_2000, 32'h0000_0344, SUP);
        check("miss fill", 1, fill_seen);
        check("fill addr", EA & 32'hFFFF_FFE0, fa);
        run_op(icmo_pkg::ICMO_OP_TOUCH, 5'd0, 32'hDEAD_0000, EA, SUP);
        check("hit no fill", 0, fill_seen);
        run_op(icmo_pkg::ICMO_OP_TOUCH, 5'd1, 32'h0, 32'h0000_8000, 5'b00000);
        check("uncached no fill", 0, fill_seen);
        run_op(icmo_pkg::ICMO_OP_TOUCH, 5'd1, 32'h0, 32'h0000_9000, 5'b00111);
        check("fault no fill", 0, fill_seen);
        check("fault exc", 3'b001, {seen.exc_program, seen.exc_data, seen.exc_debug});
        slow <= 1'b1;
        run_op(icmo_pkg::ICMO_OP_TOUCH, 5'd2, 32'h0000_0060, 32'h0001_2300, SUP);
        check("slow fill addr", 32'h0001_2360, fa);
        slow <= 1'b0;
    endtask

    task automatic t_debug_reads();
        wd = {3'd1, EA[23:5], 10'h2A5};
        dbg_read(1'b0, 1'b0, 32'hFFFF_FFFF, {wd[31:10], 10'h011});
        dbg_read(1'b0, 1'b1, 32'hFFFF_FFFF, {EA[31:10], 10'h011});
        dbg_read(1'b1, 1'b0, 32'h0000_03FF, 32'h0000_0001);
    endtask

    task automatic t_privilege();
        run_op(icmo_pkg::ICMO_OP_DBG_READ, 5'd0, 32'h0, 32'h0000_0000, 5'b01100);
        check("user read trap", 1, seen.exc_program);
        check("reg kept", 32'h0000_0001, instr_cache_debug_data_o & 32'h0000_03FF);
        run_op(icmo_pkg::ICMO_OP_DBG_READ, 5'd0, 32'h0, 32'h0000_0000, 5'b00110);
        check("read fault exc", 3'b010, {seen.exc_program, seen.exc_data, seen.exc_debug});
        check("fault reg kept", 32'h0000_0001, instr_cache_debug_data_o & 32'h0000_03FF);
        run_op(icmo_pkg::ICMO_OP_INVAL_ALL, 5'd0, 32'h0, 32'h0, 5'b01100);
        check("user inval trap", 3'b100, {seen.exc_program, seen.exc_data, seen.exc_debug});
        dbg_read(1'b0, 1'b1, 32'h0000_0010, 32'h0000_0010);
        run_op(icmo_pkg::ICMO_OP_INVAL_ALL, 5'd9, 32'h1, 32'h1, 5'b10111);
        check("inval exc", 3'b000, {seen.exc_program, seen.exc_data, seen.exc_debug});
        dbg_read(1'b0, 1'b1, 32'h0000_0010, 32'h0000_0000);
    endtask

    task automatic t_fetch_sync();
        @(posedge clk_i);
        fetch_valid_i <= 1'b1;
        fetch_addr_i <= EA;
        ctx_sync_i <= 1'b1;
        @(posedge clk_i);
        fetch_valid_i <= 1'b0;
        ctx_sync_i <= 1'b0;
        #1;
        check("fetch hit", 1, fetch_hit_o);
        check("fetch word", {3'd1, EA[23:5], 10'h2A5}, fetch_word_o);
        check("sync pair", 2'b11, {ctx_sync_done_o, prefetch_flush_o});
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        #1;
        check("reset debug data", 32'h0000_0000, instr_cache_debug_data_o);
        t_touches();
        t_fetch_sync();
        t_debug_reads();
        t_privilege();
        give_verdict();
    end
endmodule // testbench
`default_nettype wire
